// file: core/bit_skid_buffer.sv
/*
 * Two-entry buffer between the transmit core and the link.
 * Assumes the link consumer shares the clock and may stall at will.
 */
module bit_skid_buffer #(parameter int WIDTH = 1) (
	input wire logic clk,
	input wire logic rst_n,
	bit_stream_if.snk in_s,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);

	localparam logic [1:0] CNT_FULL = 2'h2;

	logic [WIDTH-1:0] d0;
	logic [WIDTH-1:0] d1;
	logic [1:0] cnt;
	logic [WIDTH-1:0] next_d0;
	logic [WIDTH-1:0] next_d1;
	logic [1:0] next_cnt;
	logic push;
	logic pop;

	assign in_s.ready = (cnt != CNT_FULL);
	assign out_valid = (cnt != 2'h0);
	assign out_data = d0;

	always_comb begin
		push = in_s.valid & in_s.ready;
		pop = out_valid & out_ready;
		next_d0 = d0;
		next_d1 = d1;
		next_cnt = cnt;
		case ({push, pop})
			2'b10: begin
				if (cnt == 2'h0) begin
					next_d0 = in_s.data;
				end else begin
					next_d1 = in_s.data;
				end
				next_cnt = cnt + 2'h1;
			end
			2'b01: begin
				next_d0 = d1;
				next_cnt = cnt - 2'h1;
			end
			2'b11: begin
				if (cnt == 2'h1) begin
					next_d0 = in_s.data;
				end else begin
					next_d0 = d1;
					next_d1 = in_s.data;
				end
			end
			default: begin
				next_cnt = cnt;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			d0 <= '0;
			d1 <= '0;
			cnt <= 2'h0;
		end else begin
			d0 <= next_d0;
			d1 <= next_d1;
			cnt <= next_cnt;
		end
	end

endmodule

// file: core/bit_stream_if.sv
/*
 * Valid/ready stream carrier between the transmit core and its buffer.
 * Assumes both ends share one clock.
 */
interface bit_stream_if #(parameter int WIDTH = 1);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

// file: core/datalink_hdlc_tx_mode_control.sv
/*
 * Transmit mode control for the second data link HDLC controller:
 * flag idle, message frames with check octets, repeated bit messages,
 * abort, APB register file and a two-entry output buffer.
 * Assumes an APB master on pclk and a link consumer on the same clock.
 */
// Design decisions made here: the APB interface to the registers and the register offsets.
module datalink_hdlc_tx_mode_control
	import dl_tx_pkg::*;
#(
	parameter int MSG_DEPTH = 128
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic link_bit,
	output logic link_valid,
	input wire logic link_ready
);

	////////////////////////////////////////////////////////////////////////
	logic [CTRL_W-1:0] ctrl;
	logic [COUNT_W-1:0] count;
	logic [COUNT_W-1:0] fill_ptr;
	logic tx_end_of_transfer_irq;
	logic mos_pend;
	logic bos_pend;
	logic [CTRL_W-1:0] next_ctrl;
	logic [COUNT_W-1:0] next_count;
	logic [COUNT_W-1:0] next_fill_ptr;
	logic next_eot;
	logic next_mos_pend;
	logic next_bos_pend;
	logic [31:0] next_prdata;
	logic [7:0] msg_mem [MSG_DEPTH];
	logic [7:0] word_addr;
	logic wr;
	logic hit_ctrl;
	logic hit_count;
	logic hit_status;
	logic hit_data;

	tx_state_e state;
	tx_state_e next_state;
	tx_state_e pick_state;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [7:0] pick_octet;
	logic [2:0] bitcnt;
	logic [2:0] next_bitcnt;
	logic [2:0] ones;
	logic [2:0] next_ones;
	logic stuff;
	logic next_stuff;
	logic [COUNT_W-1:0] byte_idx;
	logic [COUNT_W-1:0] next_idx;
	logic [COUNT_W-1:0] reps;
	logic [COUNT_W-1:0] next_reps;
	logic crc_clear;
	logic crc_shift;
	logic [15:0] crc;
	logic [15:0] crc_upd;
	logic done_evt;
	logic clr_mos;
	logic clr_bos;
	logic accept;
	logic at_end;
	logic stuffable;
	logic eff_idle;
	logic eff_append;
	logic abrupt;

	bit_stream_if #(.WIDTH(1)) tx_s ();

	////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, read data captured in the setup cycle.
	assign word_addr = {paddr[7:2], 2'b00};
	assign hit_ctrl = (word_addr == OFF_CONTROL);
	assign hit_count = (word_addr == OFF_COUNT);
	assign hit_status = (word_addr == OFF_STATUS);
	assign hit_data = (word_addr == OFF_MSG_DATA);
	assign wr = psel & penable & pwrite;
	assign pready = 1'b1;
	assign pslverr = psel & penable &
		~(hit_ctrl | hit_count | hit_status | hit_data);

	assign eff_idle = ctrl[B_IDLE] & ctrl[B_KIND];
	assign eff_append = ctrl[B_APPEND] & ctrl[B_KIND];

	always_comb begin
		next_ctrl = ctrl;
		next_count = count;
		next_fill_ptr = fill_ptr;
		next_prdata = prdata;
		next_mos_pend = mos_pend & ~clr_mos;
		next_bos_pend = bos_pend & ~clr_bos;
		next_eot = tx_end_of_transfer_irq;
		if (wr && hit_ctrl) begin
			next_ctrl = pwdata[CTRL_W-1:0];
			// Each write is a send request of the chosen kind.
			if (pwdata[B_KIND]) begin
				next_mos_pend = 1'b1;
			end else begin
				next_bos_pend = 1'b1;
			end
		end
		if (wr && hit_count) begin
			next_count = pwdata[COUNT_W-1:0];
			next_fill_ptr = '0;
		end
		if (wr && hit_data) begin
			next_fill_ptr = fill_ptr + 7'h01;
		end
		if (wr && hit_status && pwdata[0]) begin
			next_eot = 1'b0;
		end
		// A completion in the clearing cycle is kept.
		if (done_evt) begin
			next_eot = 1'b1;
		end
		if (psel && !penable && !pwrite) begin
			next_prdata = 32'h0;
			if (hit_ctrl) begin
				next_prdata[CTRL_W-1:0] = ctrl;
			end
			if (hit_count) begin
				next_prdata[COUNT_W-1:0] = count;
			end
			if (hit_status) begin
				next_prdata[5:0] = {state, bos_pend, mos_pend,
					tx_end_of_transfer_irq};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RESET;
			count <= COUNT_RESET;
			fill_ptr <= '0;
			prdata <= 32'h0;
			mos_pend <= 1'b0;
			bos_pend <= 1'b0;
			tx_end_of_transfer_irq <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			count <= next_count;
			fill_ptr <= next_fill_ptr;
			prdata <= next_prdata;
			mos_pend <= next_mos_pend;
			bos_pend <= next_bos_pend;
			tx_end_of_transfer_irq <= next_eot;
		end
	end

	// Message octets; octet 0 is also the bit-oriented pattern.
	always_ff @(posedge pclk) begin
		if (wr && hit_data) begin
			msg_mem[fill_ptr] <= pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Choice of the next octet when no frame is in flight.
	always_comb begin
		pick_state = ST_FLAG;
		pick_octet = FLAG_OCTET;
		if (ctrl[B_ABORT]) begin
			pick_state = ST_ABORT;
			pick_octet = ABORT_OCTET;
		end else if (bos_pend) begin
			pick_state = ST_BOS;
			pick_octet = msg_mem[0];
		end else if (mos_pend && !eff_idle && count != '0) begin
			pick_state = ST_DATA;
			pick_octet = msg_mem[0];
		end
	end

	assign tx_s.valid = 1'b1;
	assign tx_s.data = stuff ? 1'b0 : shreg[0];
	assign accept = tx_s.ready;
	assign stuffable = (state == ST_DATA) || (state == ST_CRC);
	assign at_end = accept && !stuff && bitcnt == LAST_BIT;
	assign crc_shift = accept && !stuff && state == ST_DATA;
	// The frame is aborted or cut over to a bit message rather than ending cleanly.
	assign abrupt = ctrl[B_ABORT] | bos_pend | eff_idle;

	always_comb begin
		next_state = state;
		next_shreg = shreg;
		next_bitcnt = bitcnt;
		next_ones = ones;
		next_stuff = stuff;
		next_idx = byte_idx;
		next_reps = reps;
		crc_clear = 1'b0;
		done_evt = 1'b0;
		clr_mos = 1'b0;
		clr_bos = 1'b0;
		if (accept && stuff) begin
			next_stuff = 1'b0;
			next_ones = 3'h0;
		end else if (accept) begin
			next_shreg = {1'b0, shreg[7:1]};
			next_bitcnt = bitcnt + 3'h1;
			if (stuffable && shreg[0]) begin
				next_ones = ones + 3'h1;
				next_stuff = (ones == STUFF_RUN - 3'h1);
			end else begin
				next_ones = 3'h0;
			end
		end
		if (at_end) begin
			case (state)
				ST_FLAG, ST_ABORT: begin
					next_state = pick_state;
					next_shreg = pick_octet;
				end
				ST_DATA: begin
					if (abrupt) begin
						clr_mos = 1'b1;
						if (!ctrl[B_ABORT] && !eff_idle &&
							ctrl[B_ABORT_DIS]) begin
							next_state = pick_state;
							next_shreg = pick_octet;
						end else begin
							next_state = ST_ABORT;
							next_shreg = ABORT_OCTET;
						end
					end else if (byte_idx == count) begin
						if (eff_append) begin
							next_state = ST_CRC;
							next_shreg = ~crc_upd[7:0];
							next_idx = '0;
						end else begin
							next_state = ST_FLAG;
							next_shreg = FLAG_OCTET;
							done_evt = 1'b1;
							clr_mos = 1'b1;
						end
					end else begin
						next_shreg = msg_mem[byte_idx];
						next_idx = byte_idx + 7'h01;
					end
				end
				ST_CRC: begin
					if (byte_idx == '0) begin
						next_shreg = ~crc[15:8];
						next_idx = 7'h01;
					end else begin
						next_state = ST_FLAG;
						next_shreg = FLAG_OCTET;
						done_evt = 1'b1;
						clr_mos = 1'b1;
					end
				end
				ST_BOS: begin
					if (ctrl[B_ABORT]) begin
						next_state = ST_ABORT;
						next_shreg = ABORT_OCTET;
					end else if (bos_pend) begin
						next_shreg = msg_mem[0];
						next_reps = 7'h01;
						clr_bos = 1'b1;
					end else if (mos_pend) begin
						next_state = ST_FLAG;
						next_shreg = FLAG_OCTET;
					end else if (count != '0 && reps == count) begin
						next_state = ST_FLAG;
						next_shreg = FLAG_OCTET;
						done_evt = 1'b1;
					end else begin
						next_shreg = msg_mem[0];
						next_reps = reps + 7'h01;
					end
				end
				default: begin
					next_state = ST_FLAG;
					next_shreg = FLAG_OCTET;
				end
			endcase
			if (next_state == ST_BOS && state != ST_BOS) begin
				next_reps = 7'h01;
				clr_bos = 1'b1;
			end
			if (next_state == ST_DATA && state != ST_DATA) begin
				next_idx = 7'h01;
				crc_clear = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_FLAG;
			shreg <= FLAG_OCTET;
			bitcnt <= 3'h0;
			ones <= 3'h0;
			stuff <= 1'b0;
			byte_idx <= '0;
			reps <= '0;
		end else begin
			state <= next_state;
			shreg <= next_shreg;
			bitcnt <= next_bitcnt;
			ones <= next_ones;
			stuff <= next_stuff;
			byte_idx <= next_idx;
			reps <= next_reps;
		end
	end

	hdlc_crc16 u_crc (
		.clk(pclk),
		.rst_n(presetn),
		.clear(crc_clear),
		.shift(crc_shift),
		.din(shreg[0]),
		.crc(crc),
		.crc_upd(crc_upd)
	);

	// The buffer holds its bits and stops the core through a stall of any length, so no line bit is lost.
	bit_skid_buffer #(.WIDTH(1)) u_buf (
		.clk(pclk),
		.rst_n(presetn),
		.in_s(tx_s),
		.out_data(link_bit),
		.out_valid(link_valid),
		.out_ready(link_ready)
	);

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_IDLE_HOLDS_FLAGS:
	assert property (at_end && state == ST_FLAG && eff_idle &&
		!ctrl[B_ABORT] && !bos_pend |=> state == ST_FLAG &&
		shreg == FLAG_OCTET)
		else $error("idle fill did not keep flags");
	AST_IDLE_FLAGS_WHEN_EMPTY:
	assert property (at_end && state == ST_FLAG && !mos_pend &&
		!bos_pend && !ctrl[B_ABORT] |=> state == ST_FLAG)
		else $error("no flag while nothing queued");
	AST_IDLE_OVERRIDES_FRAME:
	assert property (at_end && state == ST_DATA && eff_idle
		|=> state == ST_ABORT ##1 !mos_pend)
		else $error("frame survived idle fill");
	AST_BOS_IGNORES_IDLE:
	assert property (at_end && state == ST_FLAG && !ctrl[B_KIND] &&
		ctrl[B_IDLE] && bos_pend && !ctrl[B_ABORT] |=> state == ST_BOS)
		else $error("idle fill blocked bit message");
	AST_CHECK_APPEND:
	assert property (at_end && state == ST_DATA && !abrupt &&
		byte_idx == count |=> (state == ST_CRC) == $past(eff_append))
		else $error("check octets wrongly appended");
	AST_APPEND_NEEDS_MOS:
	assert property (at_end && state != ST_CRC && !ctrl[B_KIND]
		|=> state != ST_CRC)
		else $error("check octets started in bit mode");
	AST_MOS_TRIGGER:
	assert property (wr && hit_ctrl && pwdata[B_KIND] |=> mos_pend)
		else $error("frame send not queued");
	AST_BOS_TRIGGER:
	assert property (wr && hit_ctrl && !pwdata[B_KIND]
		|=> bos_pend || state == ST_BOS)
		else $error("bit message send not queued");
	AST_ABORT_PATTERN:
	assert property ($rose(state == ST_ABORT)
		|-> shreg == ABORT_OCTET && bitcnt == 3'h0)
		else $error("abort octet wrong");
	AST_AUTO_ABORT:
	assert property (at_end && state == ST_DATA && bos_pend &&
		!ctrl[B_ABORT_DIS] |=> state == ST_ABORT)
		else $error("auto abort missing");
	AST_BOS_HALT:
	assert property (at_end && state == ST_BOS && !ctrl[B_ABORT] &&
		!bos_pend && !mos_pend && count != '0 && reps == count
		|=> state == ST_FLAG && tx_end_of_transfer_irq)
		else $error("bit message did not halt");
	AST_FRAME_LENGTH:
	assert property (at_end && state == ST_DATA && !abrupt &&
		byte_idx != count |=> state == ST_DATA && byte_idx ==
		$past(byte_idx) + 7'h01)
		else $error("frame length miscounted");
	AST_ZERO_STUFF:
	assert property (accept && !stuff && stuffable && shreg[0] &&
		ones == 3'h4 |=> stuff && tx_s.data == 1'b0)
		else $error("zero not inserted");

	COV_FRAME_WITH_CHECK:
	cover property (state == ST_CRC ##[1:40] done_evt);
	COV_BOS_HALT:
	cover property (state == ST_BOS ##[1:300] done_evt);
	COV_AUTO_ABORT:
	cover property (state == ST_DATA ##1 state == ST_ABORT);

endmodule

// file: core/dl_tx_pkg.sv
/*
 * Shared constants and types for the data link transmit mode control.
 * Assumes a 32-bit APB register port and a bit-serial link stream.
 */
package dl_tx_pkg;

	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_COUNT = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_MSG_DATA = 8'h0c;

	// Field positions of datalink_tx_control.
	localparam int B_KIND = 0;
	localparam int B_APPEND = 1;
	localparam int B_IDLE = 2;
	localparam int B_ABORT = 3;
	localparam int B_ABORT_DIS = 6;
	localparam int CTRL_W = 7;
	localparam int COUNT_W = 7;

	localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 7'h00;

	localparam logic [7:0] FLAG_OCTET = 8'h7e;
	// A zero followed by seven ones, sent least significant bit first.
	localparam logic [7:0] ABORT_OCTET = 8'hfe;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	localparam logic [2:0] STUFF_RUN = 3'h5;
	localparam logic [2:0] LAST_BIT = 3'h7;

	typedef enum logic [2:0] {
		ST_FLAG = 3'b000,
		ST_DATA = 3'b001,
		ST_CRC = 3'b010,
		ST_ABORT = 3'b011,
		ST_BOS = 3'b100
	} tx_state_e;

endpackage

// file: core/hdlc_crc16.sv
/*
 * Bit-serial 16-bit HDLC frame check, reflected form.
 * Assumes bits are fed least significant bit first, one per shift.
 */
module hdlc_crc16
	import dl_tx_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic shift,
	input wire logic din,
	output logic [15:0] crc,
	output logic [15:0] crc_upd
);

	logic [15:0] next_crc;

	always_comb begin
		crc_upd = crc;
		if (shift) begin
			if (crc[0] ^ din) begin
				crc_upd = {1'b0, crc[15:1]} ^ CRC_POLY;
			end else begin
				crc_upd = {1'b0, crc[15:1]};
			end
		end
		next_crc = clear ? CRC_INIT : crc_upd;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			crc <= CRC_INIT;
		end else begin
			crc <= next_crc;
		end
	end

endmodule

// file: tb/link_sink.sv
/*
 * Link consumer standing in for the remote terminal equipment.
 * Assumes the block's link port runs on the same pclk.
 */
module link_sink (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	input wire logic hold,
	output logic link_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] phase;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			phase <= 2'h0;
		else
			phase <= phase + 2'h1;
	end
	// A slow consumer takes one bit in four, so the buffer is full three cycles in four.
	assign link_ready = !hold && (!slow || phase == 2'h3);
endmodule

// file: tb/tb.sv
/*
 * Self-checking bench for the data link transmit mode control.
 * Assumes the design package and the link_sink consumer model.
 */
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dl_tx_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, link_bit, link_valid;
	logic link_ready, pready, pslverr, slow, hold, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int n_fail, num_checks;
	logic rx[$];
	logic [7:0] oct[$];

	datalink_hdlc_tx_mode_control #(.MSG_DEPTH(128))
		datalink_hdlc_tx_mode_control_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link_bit(link_bit), .link_valid(link_valid),
		.link_ready(link_ready));
	link_sink link_sink_i (.pclk(pclk), .presetn(presetn), .slow(slow),
		.hold(hold), .link_ready(link_ready));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (presetn && link_valid && link_ready)
			rx.push_back(link_bit);
	end
//////////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_n(int n);
		repeat (n) @(posedge pclk);
	endtask
	function automatic bit is_oct(int i, logic [7:0] v);
		if (i + 8 > rx.size())
			return 0;
		for (int k = 0; k < 8; k++)
			if (rx[i + k] !== v[k])
				return 0;
		return 1;
	endfunction
	function automatic int past_flags();
		int i;
		i = 0;
		while (i < rx.size() && !is_oct(i, FLAG_OCTET))
			i++;
		while (is_oct(i, FLAG_OCTET))
			i += 8;
		return i;
	endfunction
	// Strips inserted zeros and packs frame octets up to the closing flag.
	task automatic decode();
		int i, ones, n;
		logic [7:0] b;
		oct.delete();
		i = past_flags();
		ones = 0;
		n = 0;
		while (i < rx.size() && !is_oct(i, FLAG_OCTET)) begin
			if (!(ones == 5 && rx[i] === 1'b0)) begin
				b[n] = rx[i];
				n++;
				if (n == 8) begin
					oct.push_back(b);
					n = 0;
				end
			end
			ones = (rx[i] === 1'b1) ? ones + 1 : 0;
			i++;
		end
	endtask
	function automatic logic [15:0] fcs(int n);
		logic [15:0] c;
		c = CRC_INIT;
		for (int j = 0; j < n; j++)
			for (int k = 0; k < 8; k++)
				c = (c[0] ^ oct[j][k]) ? (c >> 1) ^ CRC_POLY : c >> 1;
		return ~c;
	endfunction
	function automatic int max_run();
		int r, m;
		r = 0;
		m = 0;
		foreach (rx[i]) begin
			r = (rx[i] === 1'b1) ? r + 1 : 0;
			if (r > m)
				m = r;
		end
		return m;
	endfunction
//////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		apb(0, OFF_CONTROL, 0);
		`CHK("ctrl_rst", 32'h0, rd)
		apb(0, OFF_COUNT, 0);
		`CHK("count_rst", 32'h0, rd)
		apb(1, OFF_COUNT, 32'h7f);
		apb(0, OFF_COUNT, 0);
		`CHK("count_rw", 32'h7f, rd)
		apb(1, 8'h10, 32'hff);
		`CHK("unmapped_wr", 1'b1, err)
		apb(0, 8'h10, 0);
		`CHK("unmapped_rd", 32'h0, rd)
	endtask
	task automatic t_idle();
		rx.delete();
		wait_n(80);
		`CHK("idle", 1'b1, past_flags() + 8 > rx.size())
	endtask
	task automatic t_stall();
		logic b;
		rx.delete();
		hold <= 1'b1;
		wait_n(3);
		b = link_bit;
		repeat (8) begin
			@(posedge pclk);
			`CHK("stall_valid", 1'b1, link_valid)
			`CHK("stall_bit", b, link_bit)
		end
		hold <= 1'b0;
		wait_n(40);
		`CHK("stall_loss", 1'b1, past_flags() + 8 > rx.size())
	endtask
	task automatic t_frame(logic app, logic s);
		slow <= s;
		apb(1, OFF_COUNT, 2);
		apb(1, OFF_MSG_DATA, 32'hff);
		apb(1, OFF_MSG_DATA, 32'h7e);
		rx.delete();
		// A whole flag must precede the frame in the capture.
		wait_n(80);
		apb(1, OFF_CONTROL, {30'h0, app, 1'b1});
		wait_n(500);
		decode();
		`CHK("len", 2 + 2 * app, oct.size())
		`CHK("oct0", 8'hff, oct[0])
		`CHK("oct1", 8'h7e, oct[1])
		if (app)
			`CHK("fcs", fcs(2), {oct[3], oct[2]})
		apb(0, OFF_CONTROL, 0);
		`CHK("ctrl_rw", {30'h0, app, 1'b1}, rd)
		slow <= 1'b0;
	endtask
	task automatic t_idle_fill();
		apb(1, OFF_COUNT, 2);
		apb(1, OFF_MSG_DATA, 32'ha5);
		apb(1, OFF_MSG_DATA, 32'h5a);
		rx.delete();
		apb(1, OFF_CONTROL, 32'h5);
		wait_n(200);
		`CHK("fill", 1'b1, past_flags() + 8 > rx.size())
		rx.delete();
		wait_n(20);
		apb(1, OFF_CONTROL, 32'h1);
		wait_n(200);
		decode();
		`CHK("resume_len", 2, oct.size())
		`CHK("resume_oct", 8'ha5, oct[0])
	endtask
	task automatic t_bos(logic [6:0] n);
		int p, k;
		apb(1, OFF_COUNT, {25'h0, n});
		apb(1, OFF_MSG_DATA, 32'h3c);
		apb(1, OFF_STATUS, 32'h1);
		rx.delete();
		wait_n(20);
		// Idle and append are set too; neither may alter a bit message.
		apb(1, OFF_CONTROL, 32'h6);
		wait_n(150);
		p = past_flags();
		k = 0;
		while (is_oct(p, 8'h3c)) begin
			k++;
			p += 8;
		end
		`CHK("reps", n, k[6:0])
		`CHK("no_fcs", 1'b1, is_oct(p, FLAG_OCTET))
		apb(0, OFF_STATUS, 0);
		`CHK("eot", 1'b1, rd[0])
		apb(1, OFF_STATUS, 32'h1);
		apb(0, OFF_STATUS, 0);
		`CHK("eot_clr", 1'b0, rd[0])
	endtask
	task automatic t_abort();
		apb(1, OFF_COUNT, 1);
		apb(1, OFF_MSG_DATA, 32'h3c);
		rx.delete();
		apb(1, OFF_CONTROL, 32'h9);
		wait_n(60);
		`CHK("abort", 1'b1, max_run() >= 7)
		apb(1, OFF_CONTROL, 32'h0);
		wait_n(100);
	endtask
	task automatic t_auto(logic dis);
		apb(1, OFF_COUNT, 20);
		repeat (20) apb(1, OFF_MSG_DATA, 0);
		apb(1, OFF_CONTROL, {25'h0, dis, 6'h01});
		wait_n(60);
		rx.delete();
		apb(1, OFF_CONTROL, {25'h0, dis, 6'h00});
		wait_n(100);
		`CHK("auto_abort", !dis, max_run() >= 7)
		wait_n(200);
	endtask
	task automatic t_idle_cut();
		apb(1, OFF_COUNT, 20);
		repeat (20) apb(1, OFF_MSG_DATA, 0);
		apb(1, OFF_CONTROL, 32'h1);
		wait_n(60);
		rx.delete();
		apb(1, OFF_CONTROL, 32'h5);
		wait_n(200);
		`CHK("cut_abort", 1'b1, max_run() >= 7)
		rx.delete();
		wait_n(40);
		`CHK("cut_flags", 1'b1, past_flags() + 8 > rx.size())
	endtask
	task automatic t_bos_forever();
		int p, k;
		apb(1, OFF_COUNT, 0);
		apb(1, OFF_MSG_DATA, 32'h3c);
		rx.delete();
		wait_n(20);
		apb(1, OFF_CONTROL, 32'h0);
		wait_n(300);
		p = past_flags();
		k = 0;
		while (is_oct(p, 8'h3c)) begin
			k++;
			p += 8;
		end
		`CHK("endless", 1'b1, k > 30 && p + 8 > rx.size())
		// A frame of zero length stays queued, so only flags follow.
		apb(1, OFF_CONTROL, 32'h1);
		rx.delete();
		wait_n(40);
		`CHK("endless_stop", 1'b1, past_flags() + 8 > rx.size())
	endtask
	task automatic close_out();
		if (n_fail == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
//////////////////////////////////////////////////////////////////////////////
	initial begin
		{presetn, psel, penable, pwrite, slow, hold} = 6'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_fail = 0;
		num_checks = 0;
		wait_n(10);
		`CHK("rst_valid", 1'b0, link_valid)
		presetn <= 1'b1;
		t_regs();
		t_idle();
		t_stall();
		t_frame(1'b1, 1'b1);
		t_frame(1'b0, 1'b0);
		t_idle_fill();
		t_bos(7'd3);
		t_bos(7'd1);
		t_abort();
		t_auto(1'b0);
		t_auto(1'b1);
		t_idle_cut();
		t_bos_forever();
		close_out();
	end
	// The run needs about four thousand cycles; five times that is a hang.
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		close_out();
	end
endmodule
